// >>> design/host_bus_port.sv
// parallel host port: bus styles, addressing, interrupt summary and dma requests
`timescale 1ns/1ns
`include "host_port_defines.svh"

module host_bus_port #(
    parameter int CNT_W = `DMA_COUNT_W
) (
    input wire logic clk, // clock
    input wire logic rst, // sync reset
    input wire logic bus_cs_n, // chip select
    input wire logic bus_rd_n, // read strobe or r/w level
    input wire logic bus_wr_n, // write or data strobe
    input wire logic bus_ale, // address latch pin, also style strap
    input wire logic [7:0] bus_addr, // address lines
    input wire logic [7:0] bus_data_in, // data or multiplexed address/data in
    output logic [7:0] bus_data_out, // read data
    output logic bus_data_oe, // data bus driven
    input wire logic addressing_mode_pin, // high: indirect
    input wire logic [1:0] mode_sel_pin, // mode straps
    output logic int_n, // interrupt request
    input wire logic [5:0] sub_pending, // sub-register pending
    input wire logic aux_irq_input_0, // aux irq, falling edge
    input wire logic aux_irq_input_1, // aux irq, falling edge
    input wire logic [1:0] dma_acknowledge_in_n, // acknowledge per channel
    output logic dma_tx_request_b, // channel B tx request
    output logic dma_rx_request_b, // channel B rx request
    output logic aux_pin_0_out, // A tx request
    output logic aux_pin_0_oe, // aux pin 0 driven
    input wire logic aux_pin_0_in, // aux pin 0 level
    output logic aux_pin_1_out, // A rx request
    output logic aux_pin_1_oe, // aux pin 1 driven
    input wire logic aux_pin_1_in, // aux pin 1 level
    output logic [1:0] iom_channel_sel, // strapped channel select
    input wire logic [1:0] tx_need_load, // tx burst announce
    input wire logic [1:0][CNT_W-1:0] tx_need_count, // tx burst length
    input wire logic [1:0] rx_need_load, // rx burst announce
    input wire logic [1:0][CNT_W-1:0] rx_need_count, // rx burst length
    output host_port_pkg::fifo_word_s tx_word, // word toward a tx fifo
    output logic tx_word_valid, // tx word valid
    input wire logic tx_word_ready, // tx fifo accepts
    input wire logic [1:0][7:0] rx_top, // top byte of each rx fifo
    output logic [1:0] rx_pop, // rx fifo advance pulse
    output host_port_pkg::ext_access_s ext_access, // other registers
    input wire logic [7:0] ext_rdata // other read data
);
    typedef struct packed {
        host_port_pkg::bus_style_e style;
        logic ale_prev;
        logic strobe_prev;
        logic [7:0] addr_latch;
        logic [7:0] pointer;
        logic [7:0] mask;
        logic [1:0] dma_sel;
        logic [1:0] aux_flag;
        logic [1:0] aux_prev;
        logic terminal;
        logic [1:0] chan_sel;
        logic int_n;
        host_port_pkg::read_sel_e rsel;
        logic rchan;
        logic [7:0] data_out;
        logic data_oe;
        logic [1:0] rx_pop;
        host_port_pkg::ext_access_s ext;
        host_port_pkg::fifo_word_s push_word;
        logic push_valid;
    } port_state_s;

    port_state_s st_reg;
    port_state_s st_next;

    logic buf_in_ready;
    logic [3:0] req;
    logic [3:0] chan_enable;
    logic [3:0] burst_load;
    logic [3:0][CNT_W-1:0] burst_count;
    logic [3:0] dma_cycle;
    logic [3:0] req_hold;

    // decoded access of the current cycle
    logic sel_any;
    logic is_read;
    logic strobe;
    logic start;
    logic dma_acknowledge_in_any;
    logic dma_acknowledge_in_chan;
    logic [7:0] eff_addr;
    logic [7:0] raw_status;
    logic [7:0] shown_status;
    logic fifo_hit;
    logic fifo_chan;
    logic [1:0] tx_cycle;
    logic [1:0] rx_cycle;
    logic [1:0] aux_fall;

    always_comb begin
        st_next = st_reg;
        dma_acknowledge_in_any = !dma_acknowledge_in_n[0] || !dma_acknowledge_in_n[1];
        dma_acknowledge_in_chan = dma_acknowledge_in_n[0];
        // ack overrides chip select
        sel_any = !bus_cs_n || dma_acknowledge_in_any;
        if (st_reg.style == host_port_pkg::STYLE_STROBE) begin
            strobe = sel_any && !bus_wr_n;
            is_read = bus_rd_n;
        end else begin
            strobe = sel_any && (!bus_rd_n || !bus_wr_n);
            is_read = !bus_rd_n;
        end
        if (st_reg.style == host_port_pkg::STYLE_STRAP) begin
            strobe = 1'b0;
        end
        start = strobe && !st_reg.strobe_prev;
        st_next.strobe_prev = strobe;

        // bus style from the latch pin
        st_next.ale_prev = bus_ale;
        case (st_reg.style)
            host_port_pkg::STYLE_STRAP: begin
                st_next.style = bus_ale ? host_port_pkg::STYLE_STROBE
                                        : host_port_pkg::STYLE_SPLIT;
            end
            host_port_pkg::STYLE_STROBE, host_port_pkg::STYLE_SPLIT: begin
                if (bus_ale != st_reg.ale_prev) begin
                    st_next.style = host_port_pkg::STYLE_MUX;
                end
            end
            host_port_pkg::STYLE_MUX: begin
                st_next.style = host_port_pkg::STYLE_MUX;
            end
            default: begin
                st_next.style = host_port_pkg::STYLE_STRAP;
            end
        endcase
        if (bus_ale) begin
            st_next.addr_latch = bus_data_in;
        end

        // direct or pointer address
        if (addressing_mode_pin) begin
            eff_addr = st_reg.pointer;
        end else if (st_reg.style == host_port_pkg::STYLE_MUX) begin
            eff_addr = st_reg.addr_latch;
        end else begin
            eff_addr = bus_addr;
        end
        fifo_hit = eff_addr == `REG_FIFO_A || eff_addr == `REG_FIFO_B;
        fifo_chan = eff_addr == `REG_FIFO_B;
        if (dma_acknowledge_in_any) begin
            fifo_hit = 1'b1;
            fifo_chan = dma_acknowledge_in_chan;
        end

        // status summary and mask
        aux_fall = st_reg.aux_prev & ~{aux_irq_input_1, aux_irq_input_0};
        st_next.aux_prev = {aux_irq_input_1, aux_irq_input_0};
        raw_status = {st_reg.aux_flag, sub_pending};
        shown_status = raw_status & ~st_reg.mask;
        st_next.int_n = shown_status == 8'h00;

        st_next.terminal = !mode_sel_pin[0];
        if (st_reg.terminal) begin
            st_next.chan_sel = 2'h0;
        end else begin
            st_next.chan_sel = {aux_pin_1_in, aux_pin_0_in};
        end

        // pulses fall back
        st_next.rx_pop = 2'h0;
        st_next.ext.rd = 1'b0;
        st_next.ext.wr = 1'b0;
        st_next.push_valid = 1'b0;
        st_next.data_oe = strobe && is_read;
        st_next.rsel = host_port_pkg::RSEL_NONE;
        tx_cycle = 2'h0;
        rx_cycle = 2'h0;

        if (start) begin
            if (addressing_mode_pin && !dma_acknowledge_in_any
                && bus_addr[0] == `INDIRECT_POINTER_SEL) begin
                if (is_read) begin
                    st_next.rsel = host_port_pkg::RSEL_POINTER;
                end else begin
                    st_next.pointer = bus_data_in;
                end
            end else if (fifo_hit) begin
                st_next.rchan = fifo_chan;
                if (is_read) begin
                    st_next.rsel = host_port_pkg::RSEL_FIFO;
                    st_next.rx_pop[fifo_chan] = 1'b1;
                    rx_cycle[fifo_chan] = 1'b1;
                end else if (buf_in_ready) begin
                    st_next.push_word.chan = fifo_chan;
                    st_next.push_word.data = bus_data_in;
                    st_next.push_valid = 1'b1;
                    tx_cycle[fifo_chan] = 1'b1;
                end
            end else if (eff_addr == `REG_TOP_STATUS) begin
                if (is_read) begin
                    st_next.rsel = host_port_pkg::RSEL_STATUS;
                end
            end else if (eff_addr == `REG_MASK) begin
                if (is_read) begin
                    st_next.rsel = host_port_pkg::RSEL_MASK;
                end else begin
                    st_next.mask = bus_data_in;
                end
            end else if (eff_addr == `REG_DMA_CTRL) begin
                if (is_read) begin
                    st_next.rsel = host_port_pkg::RSEL_DMA;
                end else begin
                    st_next.dma_sel = bus_data_in[1:0];
                end
            end else begin
                // registers outside this port
                st_next.ext.addr = eff_addr;
                st_next.ext.data = bus_data_in;
                st_next.ext.rd = is_read;
                st_next.ext.wr = !is_read;
                if (is_read) begin
                    st_next.rsel = host_port_pkg::RSEL_EXT;
                end
            end
        end

        // shown aux bits clear on the edge that captures them; a new edge wins
        if (st_reg.rsel == host_port_pkg::RSEL_STATUS) begin
            st_next.aux_flag = st_reg.aux_flag & st_reg.mask[`STAT_AUX_PIN_1:`STAT_AUX_PIN_0];
        end
        st_next.aux_flag = st_next.aux_flag | aux_fall;

        // read data two cycles after the access starts
        case (st_reg.rsel)
            host_port_pkg::RSEL_STATUS: begin
                st_next.data_out = shown_status;
            end
            host_port_pkg::RSEL_MASK: begin
                st_next.data_out = st_reg.mask;
            end
            host_port_pkg::RSEL_DMA: begin
                st_next.data_out = {6'h00, st_reg.dma_sel};
            end
            host_port_pkg::RSEL_FIFO: begin
                st_next.data_out = rx_top[st_reg.rchan];
            end
            host_port_pkg::RSEL_EXT: begin
                st_next.data_out = ext_rdata;
            end
            host_port_pkg::RSEL_POINTER: begin
                st_next.data_out = st_reg.pointer;
            end
            default: begin
                st_next.data_out = st_reg.data_out;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            st_reg <= '0;
            st_reg.style <= host_port_pkg::STYLE_STRAP;
            st_reg.mask <= `MASK_RESET;
            st_reg.dma_sel <= `DMA_CTRL_RESET;
            st_reg.aux_prev <= 2'h3;
            st_reg.int_n <= 1'b1;
            st_reg.terminal <= 1'b1;
            st_reg.rsel <= host_port_pkg::RSEL_NONE;
        end else begin
            st_reg <= st_next;
        end
    end

    // index bit0 direction (0 tx), bit1 channel
    always_comb begin
        for (int i = 0; i < 4; i++) begin
            if (i >= 2) begin
                chan_enable[i] = st_reg.dma_sel[`DMA_SEL_B];
            end else begin
                chan_enable[i] = st_reg.dma_sel[`DMA_SEL_A] && st_reg.terminal;
            end
            if (i % 2 == 0) begin
                burst_load[i] = tx_need_load[i/2];
                burst_count[i] = tx_need_count[i/2];
                dma_cycle[i] = tx_cycle[i/2];
                req_hold[i] = !buf_in_ready;
            end else begin
                burst_load[i] = rx_need_load[i/2];
                burst_count[i] = rx_need_count[i/2];
                dma_cycle[i] = rx_cycle[i/2];
                req_hold[i] = 1'b0;
            end
        end
    end

    for (genvar g = 0; g < 4; g++) begin : g_req
        dma_req_channel #(
            .CNT_W(CNT_W)
        ) u_req (
            .clk(clk),
            .rst(rst),
            .enable(chan_enable[g]),
            .hold(req_hold[g]),
            .load(burst_load[g]),
            .load_count(burst_count[g]),
            .cycle(dma_cycle[g]),
            .request(req[g])
        );
    end

    two_entry_buffer #(
        .WIDTH($bits(host_port_pkg::fifo_word_s))
    ) u_tx_buf (
        .clk(clk),
        .rst(rst),
        .in_data(st_reg.push_word),
        .in_valid(st_reg.push_valid),
        .in_ready(buf_in_ready),
        .out_data(tx_word),
        .out_valid(tx_word_valid),
        .out_ready(tx_word_ready)
    );

    assign bus_data_out = st_reg.data_out;
    assign bus_data_oe = st_reg.data_oe;
    assign int_n = st_reg.int_n;
    assign dma_tx_request_b = req[2];
    assign dma_rx_request_b = req[3];
    assign aux_pin_0_out = req[0];
    assign aux_pin_1_out = req[1];
    assign aux_pin_0_oe = st_reg.terminal;
    assign aux_pin_1_oe = st_reg.terminal;
    assign iom_channel_sel = st_reg.chan_sel;
    assign rx_pop = st_reg.rx_pop;
    assign ext_access = st_reg.ext;
endmodule // host_bus_port

// >>> design/host_port_defines.svh
// register offsets, field positions, reset values and widths of the host port
`ifndef HOST_PORT_DEFINES_SVH
`define HOST_PORT_DEFINES_SVH

`define REG_TOP_STATUS 8'hc1
`define REG_MASK 8'hc2
`define REG_DMA_CTRL 8'hc3
`define REG_FIFO_A 8'h00
`define REG_FIFO_B 8'h40

`define MASK_RESET 8'hff
`define DMA_CTRL_RESET 2'h0
`define DMA_SEL_A 0
`define DMA_SEL_B 1

`define STAT_SUB_LSB 0
`define STAT_SUB_MSB 5
`define STAT_AUX_PIN_0 6
`define STAT_AUX_PIN_1 7

`define INDIRECT_POINTER_SEL 1'b0
`define DMA_COUNT_W 7

`endif

// >>> design/host_port_pkg.sv
// types shared by the host port modules
package host_port_pkg;

    typedef enum logic [3:0] {
        STYLE_STRAP = 4'h1,
        STYLE_STROBE = 4'h2,
        STYLE_SPLIT = 4'h4,
        STYLE_MUX = 4'h8
    } bus_style_e;

    typedef enum logic [2:0] {
        RSEL_NONE = 3'h0,
        RSEL_STATUS = 3'h1,
        RSEL_MASK = 3'h2,
        RSEL_DMA = 3'h3,
        RSEL_FIFO = 3'h4,
        RSEL_EXT = 3'h5,
        RSEL_POINTER = 3'h6
    } read_sel_e;

    typedef struct packed {
        logic chan;
        logic [7:0] data;
    } fifo_word_s;

    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] data;
        logic rd;
        logic wr;
    } ext_access_s;

endpackage

// >>> design/two_entry_buffer.sv
// two-entry buffer with valid/ready on both sides
`timescale 1ns/1ns
module two_entry_buffer #(
    parameter int WIDTH = 9
) (
    input wire logic clk, // clock
    input wire logic rst, // sync reset
    input wire logic [WIDTH-1:0] in_data, // word in
    input wire logic in_valid, // word offered
    output logic in_ready, // room for a word
    output logic [WIDTH-1:0] out_data, // head word
    output logic out_valid, // head valid
    input wire logic out_ready // drain accepts
);
    typedef struct packed {
        logic [1:0][WIDTH-1:0] slot;
        logic [1:0] count;
    } buf_state_s;

    buf_state_s st_reg;
    buf_state_s st_next;
    logic push;
    logic pop;

    always_comb begin
        st_next = st_reg;
        pop = st_reg.count != 2'h0 && out_ready;
        push = in_valid && st_reg.count != 2'h2;
        if (pop) begin
            st_next.slot[0] = st_reg.slot[1];
        end
        if (push) begin
            if (st_reg.count == 2'h0 || (st_reg.count == 2'h1 && pop)) begin
                st_next.slot[0] = in_data;
            end else begin
                st_next.slot[1] = in_data;
            end
        end
        st_next.count = st_reg.count + {1'b0, push} - {1'b0, pop};
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign in_ready = st_reg.count != 2'h2;
    assign out_valid = st_reg.count != 2'h0;
    assign out_data = st_reg.slot[0];
endmodule // two_entry_buffer

// >>> design/dma_req_channel.sv
// one level-held dma request with its remaining cycle count
`timescale 1ns/1ns
`include "host_port_defines.svh"
module dma_req_channel #(
    parameter int CNT_W = `DMA_COUNT_W
) (
    input wire logic clk, // clock
    input wire logic rst, // sync reset
    input wire logic enable, // dma mode for this fifo
    input wire logic hold, // data path stalled
    input wire logic load, // fifo announces a burst
    input wire logic [CNT_W-1:0] load_count, // cycles in the burst
    input wire logic cycle, // a matching bus cycle started
    output logic request // request level
);
    typedef struct packed {
        logic [CNT_W-1:0] remaining;
        logic request;
    } req_state_s;

    req_state_s st_reg;
    req_state_s st_next;

    always_comb begin
        st_next = st_reg;
        if (!enable) begin
            st_next.remaining = '0;
        end else if (load) begin
            st_next.remaining = load_count;
        end else if (cycle && st_reg.remaining != '0) begin
            st_next.remaining = st_reg.remaining - 1'b1;
        end
        // held while owed and not on hold, dropped at last cycle
        st_next.request = st_next.remaining != '0 && !hold;
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign request = st_reg.request;
endmodule // dma_req_channel

// >>> testbench/host_bus_port_props.sv
// pin-level assertions for the host port
`timescale 1ns/1ns
module host_bus_port_props #(
    parameter int CNT_W = 7
) (
    input wire logic clk, // clock
    input wire logic rst, // sync reset
    input wire logic [1:0] mode_sel_pin, // line mode straps
    input wire logic int_n, // interrupt
    input wire logic dma_tx_request_b, // B tx request
    input wire logic dma_rx_request_b, // B rx request
    input wire logic aux_pin_0_out, // A tx request
    input wire logic aux_pin_0_oe, // aux 0 driven
    input wire logic aux_pin_1_out, // A rx request
    input wire logic aux_pin_1_oe, // aux 1 driven
    input wire logic [1:0] iom_channel_sel, // channel select
    input wire logic [1:0] rx_need_load, // rx burst load
    input wire logic [1:0] rx_pop, // rx advance
    input wire host_port_pkg::ext_access_s ext_access // other registers
);
    default clocking @(posedge clk); endclocking
    chk_reset_int: assert property (rst |=> int_n)
        else $error("int after rst");
    chk_reset_req: assert property (rst |=> !dma_tx_request_b && !dma_rx_request_b
        && !aux_pin_0_out && !aux_pin_1_out) else $error("req after rst");
    chk_lt_chan_a: assert property (disable iff (rst)
        mode_sel_pin[0] [*3] |-> !aux_pin_0_out && !aux_pin_1_out)
        else $error("A req in lt");
    chk_te_pins: assert property (disable iff (rst)
        !mode_sel_pin[0] [*3] |-> aux_pin_0_oe && aux_pin_1_oe && iom_channel_sel == 2'h0)
        else $error("aux not driven");
    chk_lt_release: assert property (disable iff (rst)
        mode_sel_pin[0] [*3] |-> !aux_pin_0_oe && !aux_pin_1_oe)
        else $error("aux driven in lt");
    chk_pop_pulse: assert property (disable iff (rst) rx_pop != 2'h0 |=> rx_pop == 2'h0)
        else $error("pop too long");
    chk_pop_single: assert property (disable iff (rst) rx_pop != 2'h3)
        else $error("double pop");
    chk_ext_pulse: assert property (disable iff (rst) ext_access.rd || ext_access.wr
        |=> !ext_access.rd && !ext_access.wr) else $error("ext too long");
    chk_rx_rise: assert property (disable iff (rst)
        !dma_rx_request_b && !rx_need_load[1] |=> !dma_rx_request_b)
        else $error("rx req rose");
    chk_rxa_rise: assert property (disable iff (rst)
        !aux_pin_1_out && !rx_need_load[0] |=> !aux_pin_1_out)
        else $error("A rx req rose");
    chk_rx_drop: assert property (disable iff (rst) $fell(dma_rx_request_b) |-> rx_pop[1])
        else $error("rx req fell early");
    cover property (disable iff (rst) $fell(dma_rx_request_b));
    cover property (disable iff (rst) $fell(int_n));
    cover property (disable iff (rst) rx_pop[0]);
    cover property (disable iff (rst) ext_access.wr);
endmodule // host_bus_port_props

bind host_bus_port host_bus_port_props #(.CNT_W(CNT_W)) u_host_bus_port_props (
    .clk(clk), .rst(rst), .mode_sel_pin(mode_sel_pin), .int_n(int_n),
    .dma_tx_request_b(dma_tx_request_b), .dma_rx_request_b(dma_rx_request_b),
    .aux_pin_0_out(aux_pin_0_out), .aux_pin_0_oe(aux_pin_0_oe),
    .aux_pin_1_out(aux_pin_1_out), .aux_pin_1_oe(aux_pin_1_oe),
    .iom_channel_sel(iom_channel_sel), .rx_need_load(rx_need_load), .rx_pop(rx_pop),
    .ext_access(ext_access));

// >>> testbench/host_fifo_model.sv
// far-side fifo model: takes tx words with stalls, serves rx bytes
`timescale 1ns/1ns
module host_fifo_model (
    input wire logic clk, // clock
    input wire logic rst, // sync reset
    input wire logic stall, // hold off tx words
    input wire host_port_pkg::fifo_word_s tx_word, // tx word
    input wire logic tx_word_valid, // tx word valid
    output logic tx_word_ready, // tx accept
    output logic [1:0][7:0] rx_top, // rx fifo heads
    input wire logic [1:0] rx_pop // rx advance
);
    host_port_pkg::fifo_word_s got[$];
    logic [1:0] beat;
    // stall every fourth cycle
    assign tx_word_ready = !stall && beat != 2'h3;
    always @(posedge clk) begin
        beat <= rst ? 2'h0 : beat + 2'h1;
        if (rst) begin
            rx_top <= {8'hb0, 8'ha0};
        end else begin
            if (tx_word_valid && tx_word_ready) begin
                got.push_back(tx_word);
            end
            for (int c = 0; c < 2; c++) begin
                if (rx_pop[c]) begin
                    rx_top[c] <= rx_top[c] + 8'h01;
                end
            end
        end
    end
endmodule // host_fifo_model

// >>> testbench/test_host_bus_port.sv
// self-checking bench for the host bus port
`timescale 1ns/1ns
`include "host_port_defines.svh"
module test_host_bus_port;
    logic clk = '0, rst = '1, bus_cs_n = '1, bus_rd_n = '1, bus_wr_n = '1, bus_ale = '0;
    logic [7:0] bus_addr = '0, bus_data_in = '0, ext_rdata = '0, bus_data_out, q, v;
    logic addressing_mode_pin = '0, aux_irq_input_0 = '1, aux_irq_input_1 = '1, stall = '0;
    logic [1:0] mode_sel_pin = '0, dma_acknowledge_in_n = '1, strap = '0, tx_need_load = '0;
    logic [1:0] rx_need_load = '0, rx_pop, iom_channel_sel;
    logic [5:0] sub_pending = '0;
    logic [1:0][6:0] tx_need_count = '0, rx_need_count = '0;
    logic [1:0][7:0] rx_top;
    logic bus_data_oe, int_n, dma_tx_request_b, dma_rx_request_b, aux_pin_0_out, aux_pin_0_oe;
    logic aux_pin_1_out, aux_pin_1_oe, tx_word_valid, tx_word_ready, oe_seen, mux = '0;
    wire logic aux_pin_0_in = aux_pin_0_oe ? aux_pin_0_out : strap[0];
    wire logic aux_pin_1_in = aux_pin_1_oe ? aux_pin_1_out : strap[1];
    host_port_pkg::fifo_word_s tx_word;
    host_port_pkg::fifo_word_s exp_tx[$];
    host_port_pkg::ext_access_s ext_access, ext_seen;
    int num_errors = 0, checks = 0, cycles = 0, seed = 63, ch, i;
    int rx_exp[2] = '{160, 176};

    host_bus_port u_host_bus_port (.clk, .rst, .bus_cs_n, .bus_rd_n, .bus_wr_n, .bus_ale,
        .bus_addr, .bus_data_in, .bus_data_out, .bus_data_oe, .addressing_mode_pin,
        .mode_sel_pin, .int_n, .sub_pending, .aux_irq_input_0, .aux_irq_input_1,
        .dma_acknowledge_in_n, .dma_tx_request_b, .dma_rx_request_b, .aux_pin_0_out,
        .aux_pin_0_oe, .aux_pin_0_in, .aux_pin_1_out, .aux_pin_1_oe, .aux_pin_1_in,
        .iom_channel_sel, .tx_need_load, .tx_need_count, .rx_need_load, .rx_need_count,
        .tx_word, .tx_word_valid, .tx_word_ready, .rx_top, .rx_pop, .ext_access, .ext_rdata);
    host_fifo_model u_host_fifo_model (.clk, .rst, .stall, .tx_word, .tx_word_valid,
        .tx_word_ready, .rx_top, .rx_pop);

    initial forever #2 clk = ~clk;

    task automatic give_verdict;
        $display("checks=%0d errors=%0d", checks, num_errors);
        if (num_errors == 0 && checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    always @(posedge clk) begin
        cycles++;
        if (cycles == 5000) begin
            num_errors++;
            give_verdict();
        end
    end

    task automatic cmp8(input logic [7:0] got, input logic [7:0] exp);
        checks++;
        if (got !== exp) begin
            num_errors++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic cmp1(input logic got, input logic exp);
        cmp8({7'h00, got}, {7'h00, exp});
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    // dk nonzero: acknowledged fifo cycle
    task automatic bus(input logic [1:0] dk, input logic wr, input logic [7:0] a, d);
        @(posedge clk) #1;
        if (mux) begin
            {bus_ale, bus_data_in} = {1'h1, a};
            @(posedge clk) #1;
            bus_ale = 1'h0;
        end
        {bus_addr, bus_data_in, dma_acknowledge_in_n} = {mux ? 8'hff : a, d, ~dk};
        {bus_cs_n, bus_rd_n, bus_wr_n} = {dk != 2'h0, wr, !wr};
        @(posedge clk) #1;
        {ext_seen, oe_seen} = {ext_access, bus_data_oe};
        @(posedge clk) #1;
        q = bus_data_out;
        {bus_cs_n, bus_rd_n, bus_wr_n, dma_acknowledge_in_n} = 5'h1f;
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        bus(2'h0, 1'h1, a, d);
    endtask

    task automatic rdc(input logic [7:0] a, input logic [7:0] e);
        bus(2'h0, 1'h0, a, 8'h00);
        cmp8(q, e);
    endtask

    task automatic load(input logic tx, input int c, input logic [6:0] n);
        @(posedge clk) #1;
        if (tx)
            {tx_need_count[c], tx_need_load[c]} = {n, 1'h1};
        else
            {rx_need_count[c], rx_need_load[c]} = {n, 1'h1};
        @(posedge clk) #1;
        {tx_need_load, rx_need_load} = 4'h0;
        tick(2);
    endtask

    function automatic logic rq(input int c, input logic tx);
        return c ? (tx ? dma_tx_request_b : dma_rx_request_b) : (tx ? aux_pin_0_out : aux_pin_1_out);
    endfunction

    initial begin
        tick(4);
        rst = 1'h0;
        tick(2);
        rdc(`REG_MASK, 8'hff);
        rdc(`REG_TOP_STATUS, 8'h00);
        v = 8'($random(seed));
        wr(`REG_MASK, v);
        rdc(`REG_MASK, v);
        wr(`REG_MASK, 8'h00);
        sub_pending = 6'($random(seed)) | 6'h01;
        tick(3);
        cmp1(int_n, 1'h0);
        rdc(`REG_TOP_STATUS, {2'h0, sub_pending});
        cmp1(int_n, 1'h0);
        wr(`REG_MASK, 8'hff);
        cmp1(int_n, 1'h1);
        wr(`REG_MASK, 8'h00);
        tick(1);
        cmp1(int_n, 1'h0);
        {sub_pending, aux_irq_input_0} = 7'h00;
        tick(4);
        cmp1(int_n, 1'h0);
        rdc(`REG_TOP_STATUS, 8'h40);
        tick(1);
        cmp1(int_n, 1'h1);
        wr(`REG_MASK, 8'h80);
        aux_irq_input_1 = 1'h0;
        tick(4);
        cmp1(int_n, 1'h1);
        rdc(`REG_TOP_STATUS, 8'h00);
        wr(`REG_MASK, 8'h00);
        rdc(`REG_TOP_STATUS, 8'h80);
        ext_rdata = 8'($random(seed));
        rdc(8'h10, ext_rdata);
        cmp8(ext_seen.addr, 8'h10);
        cmp1(ext_seen.rd & oe_seen, 1'h1);
        addressing_mode_pin = 1'h1;
        wr({7'($random(seed)), 1'h0}, `REG_MASK);
        wr({7'($random(seed)), 1'h1}, 8'h5a);
        addressing_mode_pin = 1'h0;
        rdc(`REG_MASK, 8'h5a);
        load(1'h0, 1, 7'h02);
        cmp1(dma_rx_request_b, 1'h0);
        wr(`REG_DMA_CTRL, 8'h03);
        for (ch = 0; ch < 2; ch++) begin
            load(1'h0, ch, 7'h03);
            cmp1(rq(ch, 1'h0), 1'h1);
            for (i = 0; i < 3; i++) begin
                bus(i < 2 ? (ch ? 2'h2 : 2'h1) : 2'h0, 1'h0,
                    i < 2 ? 8'($random(seed)) : (ch ? `REG_FIFO_B : `REG_FIFO_A), 8'h00);
                cmp8(q, 8'(rx_exp[ch]));
                rx_exp[ch]++;
                cmp1(rq(ch, 1'h0), i < 2);
            end
            stall = 1'h1;
            load(1'h1, ch, 7'h04);
            for (i = 0; i < 4; i++) begin
                if (i == 2) begin
                    tick(2);
                    cmp1(rq(ch, 1'h1), 1'h0);
                    stall = 1'h0;
                    tick(6);
                    cmp1(rq(ch, 1'h1), 1'h1);
                end
                v = 8'($random(seed));
                exp_tx.push_back({ch[0], v});
                bus(ch ? 2'h2 : 2'h1, 1'h1, 8'($random(seed)), v);
            end
            tick(1);
            cmp1(rq(ch, 1'h1), 1'h0);
        end
        tick(8);
        cmp8(8'(u_host_fifo_model.got.size()), 8'(exp_tx.size()));
        foreach (exp_tx[k]) begin
            cmp8(u_host_fifo_model.got[k].data, exp_tx[k].data);
            cmp1(u_host_fifo_model.got[k].chan, exp_tx[k].chan);
        end
        strap = 2'($random(seed));
        mode_sel_pin = 2'h1;
        tick(4);
        cmp8({6'h00, iom_channel_sel}, {6'h00, strap});
        cmp1(aux_pin_0_oe | aux_pin_1_oe, 1'h0);
        load(1'h0, 0, 7'h02);
        cmp1(aux_pin_1_out, 1'h0);
        load(1'h0, 1, 7'h01);
        cmp1(dma_rx_request_b, 1'h1);
        bus(2'h2, 1'h0, 8'($random(seed)), 8'h00);
        cmp8(q, 8'(rx_exp[1]));
        mode_sel_pin = 2'h0;
        mux = 1'h1;
        rdc(`REG_MASK, 8'h5a);
        rdc(`REG_MASK, 8'h5a);
        {rst, mux} = 2'h2;
        tick(4);
        rst = 1'h0;
        tick(2);
        rdc(`REG_MASK, 8'hff);
        give_verdict();
    end
endmodule // test_host_bus_port
